// >>> dv/power_stage_model.sv
// Purpose: Switch, transformer and sense comparators seen by the block.
// Assumes: Fixed on-time; valley crossings every 64 cycles while ringing.
// Notes: With ringing off the valley comparator stays quiet, as on a damped drain.
`timescale 1ns/10ps
`default_nettype none
module power_stage_model #(
   parameter int unsigned ON_CYC = 20
) (
   // Clock
   input wire logic ref_clk,
   // Switch side
   input wire logic gate_drive,
   input wire logic ringing,
   output logic peak_reached,
   output logic core_reset_cross
);
   logic [11:0] on_q = 12'h000;
   logic [11:0] off_q = 12'h000;
   always @(posedge ref_clk) begin
      on_q <= gate_drive ? on_q + 12'h001 : 12'h000;
      off_q <= gate_drive ? 12'h000 : off_q + 12'h001;
   end
   // Current ramps only while the switch conducts.
   assign peak_reached = gate_drive && on_q >= 12'(ON_CYC);
   assign core_reset_cross = ringing && !gate_drive && off_q[5];
endmodule // power_stage_model
`default_nettype wire

// >>> dv/qr_switch_checker.sv
// Purpose: Port-level timing checks for the switch control block.
// Assumes: Every comparator input passes a two-flop synchroniser.
// Notes: Bounds leave room for that synchroniser latency.
`timescale 1ns/10ps
`default_nettype none
module qr_switch_checker
   import qr_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Watched ports
   input wire logic peak_reached,
   input wire logic skip_active,
   input wire logic ov_above_trip,
   input wire logic feedback_input_grounded,
   input wire logic supply_collapsed,
   input wire logic gate_drive,
   input wire logic skip_source_en,
   input wire logic overvoltage_latch,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr
);
   logic fast_q, fast_d;
   logic [11:0] off_q, off_d;
   // The variant is shadowed from control writes so the off-time bound follows it.
   always_comb begin
      fast_d = fast_q;
      if (reg_wr && reg_addr == ADDR_CTRL) begin
         fast_d = reg_wdata[CTRL_FAST_BIT];
      end
      off_d = gate_drive ? 12'h000 : off_q + {11'h000, off_q != 12'hfff};
      if (!rst_n) begin
         fast_d = 1'b0;
         off_d = 12'h000;
      end
   end
   always_ff @(posedge ref_clk) begin
      fast_q <= fast_d;
      off_q <= off_d;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_peak_seen;
      gate_drive && $rose(peak_reached);
   endsequence
   sequence s_supply_held;
      (!supply_collapsed) [*4] ##0 overvoltage_latch;
   endsequence
   a_skip_src_inv: assert property (skip_source_en == !gate_drive)
      else $error("skip source not the inverse of the gate");
   a_peak_ends_on: assert property (s_peak_seen |-> ##[1:4] !gate_drive)
      else $error("gate stayed high after peak current");
   a_min_off_hold: assert property ($rose(gate_drive) |->
      off_q + 12'h002 >= (fast_q ? MIN_OFF_FAST_CYC : MIN_OFF_SLOW_CYC))
      else $error("gate restarted inside the minimum off time");
   a_latch_holds: assert property (s_supply_held |=> overvoltage_latch)
      else $error("latch released without supply collapse");
   a_latch_no_gate: assert property (overvoltage_latch |-> !gate_drive)
      else $error("gate driven while latched off");
   a_fbgnd_no_gate: assert property (feedback_input_grounded [*4] |-> !gate_drive)
      else $error("gate driven with feedback grounded");
   a_skip_no_start: assert property (skip_active [*4] |-> !$rose(gate_drive))
      else $error("gate started while skipping");
   a_latch_needs_ov: assert property ($rose(overvoltage_latch) |-> $past(ov_above_trip, 3))
      else $error("latch set without an overvoltage sample");
endmodule // qr_switch_checker
bind qr_switch_ctrl qr_switch_checker u_chk (.ref_clk, .rst_n, .peak_reached, .skip_active,
   .ov_above_trip, .feedback_input_grounded, .supply_collapsed, .gate_drive, .skip_source_en,
   .overvoltage_latch, .reg_addr, .reg_wdata, .reg_wr);
`default_nettype wire

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the switch control block.
// Assumes: Power stage model closes the loop around the gate drive.
// Notes: Off times are counted from the observed fall to the observed rise.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import qr_ctrl_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ringing = 1'b1;
   logic skip_active = 1'b0, ov_above_trip = 1'b0, feedback_input_grounded = 1'b0;
   logic supply_collapsed = 1'b0, supply_ok = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic peak_reached, core_reset_cross, gate_drive, skip_source_en, overvoltage_latch, irq;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   int err_count = 0, samples_checked = 0, n;
   always #4 ref_clk = ~ref_clk;
   power_stage_model u_stage (.ref_clk, .gate_drive, .ringing, .peak_reached, .core_reset_cross);
   qr_switch_ctrl u_dut (.ref_clk, .rst_n, .peak_reached, .skip_active, .core_reset_cross,
      .ov_above_trip, .feedback_input_grounded, .supply_collapsed, .supply_ok, .gate_drive,
      .skip_source_en, .overvoltage_latch, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq);
   task automatic end_sim();
      if (err_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h got %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", 16'(e), 16'(reg_rdata & m));
   endtask
   // A bounded wait; when the level must come, running out ends the run.
   task automatic wait_gate(input logic v, input int lim, input bit must, output int cnt);
      cnt = lim;
      for (int i = 0; i < lim; i++) begin
         @(posedge ref_clk);
         #1;
         if (gate_drive === v) begin
            cnt = i;
            break;
         end
      end
      if (must && cnt == lim) begin
         chk("gate_drive", 16'(v), 16'(gate_drive));
         end_sim();
      end
   endtask
   task automatic meas(input int lo, input int hi);
      int c;
      wait_gate(1'b0, 200, 1'b1, c);
      wait_gate(1'b1, 3000, 1'b1, c);
      chk("off_cycles", 16'h0001, 16'(c >= lo && c <= hi));
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(ADDR_CTRL, CTRL_RESET, 8'hff);
      rd(ADDR_IRQ_MASK, IRQ_MASK_RESET, 8'hff);
      wr(4'hf, 8'hff);
      rd(4'hf, 8'h00, 8'hff);
      wait_gate(1'b1, 3000, 1'b1, n);
      chk("first_off", 16'h0001, 16'(n >= 980));
      meas(1050, 1070);
      chk("irq", 16'h0000, 16'(irq));
      @(posedge ref_clk) ringing <= 1'b0;
      meas(995, 1010);
      wr(ADDR_CTRL, 8'h03);
      meas(620, 635);
      @(posedge ref_clk) ringing <= 1'b1;
      meas(600, 618);
      wr(ADDR_IRQ_STATUS, 8'h1f);
      @(posedge ref_clk) skip_active <= 1'b1;
      wait_gate(1'b0, 200, 1'b1, n);
      wait_gate(1'b1, 1500, 1'b0, n);
      chk("skip_hold", 16'h05dc, 16'(n));
      @(posedge ref_clk) ringing <= 1'b0;
      wait_gate(1'b1, 1500, 1'b0, n);
      chk("skip_wait", 16'h05dc, 16'(n));
      rd(ADDR_IRQ_STATUS, 8'h06, 8'h06);
      @(posedge ref_clk) skip_active <= 1'b0;
      wait_gate(1'b1, 8, 1'b1, n);
      @(posedge ref_clk) feedback_input_grounded <= 1'b1;
      ringing <= 1'b1;
      wait_gate(1'b0, 8, 1'b1, n);
      wait_gate(1'b1, 2000, 1'b0, n);
      chk("fb_hold", 16'h07d0, 16'(n));
      @(posedge ref_clk) feedback_input_grounded <= 1'b0;
      wait_gate(1'b1, 1500, 1'b1, n);
      wr(ADDR_IRQ_MASK, 8'h10);
      @(posedge ref_clk) ov_above_trip <= 1'b1;
      wait_gate(1'b0, 200, 1'b1, n);
      repeat (600) @(posedge ref_clk);
      #1;
      chk("latch", 16'h0001, 16'(overvoltage_latch));
      chk("irq", 16'h0001, 16'(irq));
      rd(ADDR_STATE, 8'h0f, 8'hff);
      @(posedge ref_clk) ov_above_trip <= 1'b0;
      wait_gate(1'b1, 2000, 1'b0, n);
      chk("latch_hold", 16'h07d0, 16'(n));
      wr(ADDR_IRQ_STATUS, 8'h10);
      rd(ADDR_IRQ_STATUS, 8'h00, 8'h10);
      chk("irq", 16'h0000, 16'(irq));
      @(posedge ref_clk) supply_collapsed <= 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      chk("latch", 16'h0000, 16'(overvoltage_latch));
      @(posedge ref_clk) supply_collapsed <= 1'b0;
      wait_gate(1'b1, 1500, 1'b1, n);
      // Leaving the supply run window must end the pulse and block restarts.
      @(posedge ref_clk) supply_ok <= 1'b0;
      wait_gate(1'b0, 8, 1'b1, n);
      wait_gate(1'b1, 1500, 1'b0, n);
      chk("supply_hold", 16'h05dc, 16'(n));
      @(posedge ref_clk) supply_ok <= 1'b1;
      wr(ADDR_CTRL, 8'h01);
      wait_gate(1'b1, 1500, 1'b0, n);
      chk("disabled_hold", 16'h05dc, 16'(n));
      wr(ADDR_CTRL, 8'h03);
      wait_gate(1'b1, 1500, 1'b1, n);
      end_sim();
   end
endmodule // testbench
`default_nettype wire

// >>> rtl/qr_ctrl_pkg.sv
// Purpose: Constants shared by the quasi-resonant switch control logic.
// Assumes: 125 MHz timing clock (8 ns period).
// Notes: Times are kept in nanoseconds and converted to cycles here.
package qr_ctrl_pkg;

   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned CNT_W = 12;

   // Restart timeout after the last core-reset crossing or turn-off.
   localparam int unsigned RESTART_TIMEOUT_NS = 5000;
   // Minimum off time, slow and fast variants.
   localparam int unsigned MIN_OFF_SLOW_NS = 8000;
   localparam int unsigned MIN_OFF_FAST_NS = 4500;
   // Overvoltage plateau sample delay, slow and fast variants.
   localparam int unsigned OV_SAMPLE_SLOW_NS = 4500;
   localparam int unsigned OV_SAMPLE_FAST_NS = 1500;
   // Skip-level sense source current while the drive is low, in microamps.
   localparam int unsigned SKIP_SOURCE_UA = 200;
   // Analog levels handled by the comparators, in millivolts.
   localparam int unsigned CORE_RESET_LEVEL_MV = 50;
   localparam int unsigned OV_REF_MV = 5000;
   localparam int unsigned OV_TRIP_MV = 7200;

   // Least times round up to whole cycles.
   localparam logic [CNT_W-1:0] RESTART_TIMEOUT_CYC =
      CNT_W'((RESTART_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] MIN_OFF_SLOW_CYC =
      CNT_W'((MIN_OFF_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] MIN_OFF_FAST_CYC =
      CNT_W'((MIN_OFF_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] OV_SAMPLE_SLOW_CYC =
      CNT_W'((OV_SAMPLE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] OV_SAMPLE_FAST_CYC =
      CNT_W'((OV_SAMPLE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Register offsets.
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATE = 4'h1;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;

   // Control register fields.
   localparam int unsigned CTRL_FAST_BIT = 0;
   localparam int unsigned CTRL_ENABLE_BIT = 1;
   localparam logic [7:0] CTRL_RESET = 8'h02;

   // Interrupt status bit positions.
   localparam int unsigned IRQ_TURN_ON = 0;
   localparam int unsigned IRQ_TURN_OFF = 1;
   localparam int unsigned IRQ_SKIP = 2;
   localparam int unsigned IRQ_TIMEOUT = 3;
   localparam int unsigned IRQ_LATCH = 4;
   localparam int unsigned IRQ_W = 5;
   localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_ON,
      ST_WAIT,
      ST_LATCHED
   } drive_state_t;

endpackage

// >>> rtl/qr_switch_ctrl.sv
// Purpose: Gate-drive sequencing for a free-running quasi-resonant flyback.
// Assumes: Comparators and supply monitor are external; 125 MHz clock.
// Notes: Operation
`timescale 1ns/10ps
`default_nettype none
module qr_switch_ctrl
   import qr_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Comparator inputs
   input wire logic peak_reached,
   input wire logic skip_active,
   input wire logic core_reset_cross,
   input wire logic ov_above_trip,
   input wire logic feedback_input_grounded,
   input wire logic supply_collapsed,
   input wire logic supply_ok,
   // Power stage outputs
   output logic gate_drive,
   output logic skip_source_en,
   output logic overvoltage_latch,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Interrupt
   output logic irq
);
   import qr_ctrl_pkg::*;

   logic peak_s;
   logic skip_s;
   logic cross_s;
   logic ov_s;
   logic fb_gnd_s;
   logic collapse_s;
   logic supply_s;

   sync2 #(.W(7)) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .async_in({peak_reached, skip_active, core_reset_cross, ov_above_trip,
                 feedback_input_grounded, supply_collapsed, supply_ok}),
      .sync_out({peak_s, skip_s, cross_s, ov_s, fb_gnd_s, collapse_s, supply_s})
   );

   // Comparators may glitch at the threshold; the edge is taken after sync.
   logic cross_prev_q;
   logic cross_prev_d;
   logic cross_edge;

   drive_state_t state_q;
   drive_state_t state_d;
   logic [CNT_W-1:0] off_cnt_q;
   logic [CNT_W-1:0] off_cnt_d;
   logic [CNT_W-1:0] tmo_cnt_q;
   logic [CNT_W-1:0] tmo_cnt_d;
   logic sampled_q;
   logic sampled_d;
   logic gate_q;
   logic gate_d;
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [IRQ_W-1:0] status_q;
   logic [IRQ_W-1:0] status_d;
   logic [IRQ_W-1:0] mask_q;
   logic [IRQ_W-1:0] mask_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   logic fast;
   logic enable;
   logic min_off_done;
   logic tmo_done;
   logic sample_now;
   logic [IRQ_W-1:0] events;

   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      sat_inc = (v == '1) ? v : v + CNT_W'(1);
   endfunction

   assign fast = ctrl_q[CTRL_FAST_BIT];
   assign enable = ctrl_q[CTRL_ENABLE_BIT];
   assign cross_edge = cross_s && !cross_prev_q;
   assign min_off_done = off_cnt_q >= (fast ? MIN_OFF_FAST_CYC : MIN_OFF_SLOW_CYC);
   assign tmo_done = tmo_cnt_q >= RESTART_TIMEOUT_CYC;
   assign sample_now = (state_q == ST_OFF || state_q == ST_WAIT) && !sampled_q &&
                       off_cnt_q == (fast ? OV_SAMPLE_FAST_CYC : OV_SAMPLE_SLOW_CYC);

   always_comb begin
      cross_prev_d = cross_s;
      state_d = state_q;
      gate_d = 1'b0;
      off_cnt_d = sat_inc(off_cnt_q);
      sampled_d = sampled_q || sample_now;
      tmo_cnt_d = cross_edge ? '0 : sat_inc(tmo_cnt_q);
      events = '0;
      case (state_q)
         ST_ON: begin
            gate_d = 1'b1;
            // Current sense ends the on time; feedback grounding also stops it.
            if (peak_s || fb_gnd_s || !enable || !supply_s) begin
               state_d = ST_OFF;
               gate_d = 1'b0;
               off_cnt_d = '0;
               sampled_d = 1'b0;
               tmo_cnt_d = '0;
               events[IRQ_TURN_OFF] = 1'b1;
            end
         end
         ST_OFF, ST_WAIT: begin
            if (sample_now && ov_s) begin
               state_d = ST_LATCHED;
               events[IRQ_LATCH] = 1'b1;
            end else if (min_off_done && enable && supply_s && !fb_gnd_s) begin
               if (skip_s) begin
                  // Start events are swallowed while skipping.
                  if ((cross_edge || tmo_done) && state_q == ST_OFF) begin
                     events[IRQ_SKIP] = 1'b1;
                  end
                  if (tmo_done) begin
                     state_d = ST_WAIT;
                  end
               end else if (cross_edge) begin
                  state_d = ST_ON;
                  gate_d = 1'b1;
                  events[IRQ_TURN_ON] = 1'b1;
               end else if (tmo_done) begin
                  state_d = ST_ON;
                  gate_d = 1'b1;
                  events[IRQ_TURN_ON] = 1'b1;
                  events[IRQ_TIMEOUT] = 1'b1;
               end
            end
         end
         ST_LATCHED: begin
            // Only a supply collapse releases the latch.
            if (collapse_s) begin
               state_d = ST_OFF;
               off_cnt_d = '0;
               sampled_d = 1'b1;
            end
         end
         default: state_d = ST_OFF;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cross_prev_q <= 1'b0;
         state_q <= ST_OFF;
         gate_q <= 1'b0;
         off_cnt_q <= '0;
         tmo_cnt_q <= '0;
         sampled_q <= 1'b1;
      end else begin
         cross_prev_q <= cross_prev_d;
         state_q <= state_d;
         gate_q <= gate_d;
         off_cnt_q <= off_cnt_d;
         tmo_cnt_q <= tmo_cnt_d;
         sampled_q <= sampled_d;
      end
   end

   // Register file; a status set wins over a write-one clear.
   always_comb begin
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      status_d = status_q;
      rdata_d = 8'h00;
      if (reg_wr) begin
         if (reg_addr == ADDR_CTRL) begin
            ctrl_d = reg_wdata & 8'h03;
         end else if (reg_addr == ADDR_IRQ_STATUS) begin
            status_d = status_q & ~reg_wdata[IRQ_W-1:0];
         end else if (reg_addr == ADDR_IRQ_MASK) begin
            mask_d = reg_wdata[IRQ_W-1:0];
         end
      end
      status_d = status_d | events;
      if (reg_rd) begin
         if (reg_addr == ADDR_CTRL) begin
            rdata_d = ctrl_q;
         end else if (reg_addr == ADDR_STATE) begin
            rdata_d = {3'b000, skip_s, sampled_q, state_q == ST_LATCHED, state_q};
         end else if (reg_addr == ADDR_IRQ_STATUS) begin
            rdata_d = {3'b000, status_q};
         end else if (reg_addr == ADDR_IRQ_MASK) begin
            rdata_d = {3'b000, mask_q};
         end else begin
            rdata_d = 8'h00;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RESET;
         mask_q <= IRQ_MASK_RESET[IRQ_W-1:0];
         status_q <= '0;
         rdata_q <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
         status_q <= status_d;
         rdata_q <= rdata_d;
      end
   end

   assign gate_drive = gate_q;
   assign skip_source_en = !gate_q;
   assign overvoltage_latch = state_q == ST_LATCHED;
   assign reg_rdata = rdata_q;
   assign irq = |(status_q & mask_q);
endmodule // qr_switch_ctrl
`default_nettype wire

// >>> rtl/sync2.sv
// Purpose: Two-flop synchroniser for comparator levels.
// Assumes: Inputs are slow analog comparator levels.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Data
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule // sync2
`default_nettype wire
